// ### dlc_low_carrier.sv
`timescale 1ns/1ps
module dlc_low_carrier (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [3:0] low_carrier_select,
	input wire logic low_carrier_output_disable,
	input wire logic low_carrier_invert,
	input wire logic low_carrier_sync_enable,
	input wire logic carrier_input_pin_1,
	input wire logic carrier_input_pin_2,
	input wire logic reference_clock_out,
	input wire logic pwmOut1,
	input wire logic pwmOut2,
	input wire logic modSource,
	output logic lowCarrier,
	output logic lowCarrierPinOut,
	output logic lowCarrierPinOe,
	output logic highAllowed
);
	// ==========================================
	// Reset release
	logic [1:0] rstSync_reg;
	logic rstN;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rstSync_reg <= 2'h0;
		end else begin
			rstSync_reg <= {rstSync_reg[0], 1'b1};
		end
	end
	assign rstN = rstSync_reg[1];

	// ==========================================
	// Pin synchronisers
	logic pin1Sync;
	logic pin2Sync;
	dlc_pin_sync uPin1 (
		.mclk(mclk),
		.rstN(rstN),
		.pinIn(carrier_input_pin_1),
		.pinOut(pin1Sync)
	);
	dlc_pin_sync uPin2 (
		.mclk(mclk),
		.rstN(rstN),
		.pinIn(carrier_input_pin_2),
		.pinOut(pin2Sync)
	);

	// ==========================================
	// Source select
	logic selected;
	always_comb begin
		case (low_carrier_select)
			dlc_pkg::SEL_GROUND: selected = 1'b0;
			dlc_pkg::SEL_PIN1: selected = pin1Sync;
			dlc_pkg::SEL_PIN2: selected = pin2Sync;
			dlc_pkg::SEL_REFCLK: selected = reference_clock_out;
			dlc_pkg::SEL_PWM1: selected = pwmOut1;
			dlc_pkg::SEL_PWM2: selected = pwmOut2;
			// Reserved codes behave as ground
			default: selected = 1'b0;
		endcase
	end

	logic carrierNext;
	assign carrierNext = selected ^ low_carrier_invert;

	logic carrier_reg;
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			carrier_reg <= dlc_pkg::CTRL_RESET;
			lowCarrier <= dlc_pkg::CTRL_RESET;
		end else begin
			carrier_reg <= carrierNext;
			lowCarrier <= carrierNext;
		end
	end

	// ==========================================
	// Pin drive
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			lowCarrierPinOut <= 1'b0;
			lowCarrierPinOe <= 1'b0;
		end else begin
			lowCarrierPinOut <= carrierNext;
			lowCarrierPinOe <= ~low_carrier_output_disable;
		end
	end

	// ==========================================
	// Switch to high carrier; held low until permitted
	logic fallEdge;
	assign fallEdge = carrier_reg & ~carrierNext;
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			highAllowed <= 1'b0;
		end else if (!modSource) begin
			highAllowed <= 1'b0;
		end else if (!low_carrier_sync_enable || fallEdge) begin
			highAllowed <= 1'b1;
		end
	end
endmodule // dlc_low_carrier

// ### dlc_pkg.sv
// Overview of operation
// - Select code 0000 gives ground, 0001 carrier pin 1, 0010 carrier pin 2, 0011 reference clock.
// - Select code 0100 gives compare/PWM channel 1 output and 0101 gives channel 2 output.
// - A set output disable bit stops the low carrier from driving its output pin.
// - A set invert bit inverts the selected low carrier before use.
// - A set sync bit makes the switch to the high carrier wait for a low carrier falling edge.
package dlc_pkg;
	// ==========================================
	// Select field
	localparam int SEL_WIDTH = 4;
	localparam logic [3:0] SEL_GROUND = 4'h0;
	localparam logic [3:0] SEL_PIN1 = 4'h1;
	localparam logic [3:0] SEL_PIN2 = 4'h2;
	localparam logic [3:0] SEL_REFCLK = 4'h3;
	localparam logic [3:0] SEL_PWM1 = 4'h4;
	localparam logic [3:0] SEL_PWM2 = 4'h5;
	// ==========================================
	// Reset values
	localparam logic [3:0] SEL_RESET = 4'h0;
	localparam logic CTRL_RESET = 1'b0;
	// Pin synchroniser depth
	localparam int SYNC_STAGES = 3;
endpackage

// ### dlc_pin_sync.sv
`timescale 1ns/1ps
module dlc_pin_sync (
	input wire logic mclk,
	input wire logic rstN,
	input wire logic pinIn,
	output logic pinOut
);
	logic [dlc_pkg::SYNC_STAGES-1:0] stage_reg;
	// Change taken once stages two and three agree
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			stage_reg <= '0;
			pinOut <= 1'b0;
		end else begin
			stage_reg <= {stage_reg[1:0], pinIn};
			if (stage_reg[1] == stage_reg[2]) begin
				pinOut <= stage_reg[2];
			end
		end
	end
endmodule // dlc_pin_sync

// ### dlc_low_carrier_monitor.sv
`timescale 1ns/1ps
module dlc_low_carrier_monitor (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [3:0] low_carrier_select,
	input wire logic low_carrier_output_disable,
	input wire logic low_carrier_invert,
	input wire logic low_carrier_sync_enable,
	input wire logic pwmOut1,
	input wire logic modSource,
	input wire logic lowCarrier,
	input wire logic lowCarrierPinOe,
	input wire logic highAllowed
);
	// ====
	// Outputs lag release, so each check except a_sync_wait waits three edges
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_pwm_path: assert property ($past(reset_n, 3) && low_carrier_select == 4'h4
		|=> lowCarrier == ($past(pwmOut1) ^ $past(low_carrier_invert))) else $error("pwm");
	a_ground_path: assert property ($past(reset_n, 3) && low_carrier_select == 4'h0
		|=> lowCarrier == $past(low_carrier_invert)) else $error("gnd");
	a_pin_enable: assert property ($past(reset_n, 3)
		|-> lowCarrierPinOe == !$past(low_carrier_output_disable)) else $error("oe");
	a_sync_wait: assert property (low_carrier_sync_enable && lowCarrier && !highAllowed
		##1 lowCarrier |-> !highAllowed) else $error("sync");
	a_free_switch: assert property ($past(reset_n, 3) && modSource && !low_carrier_sync_enable
		|=> highAllowed) else $error("free");
endmodule // dlc_low_carrier_monitor
bind dlc_low_carrier dlc_low_carrier_monitor dlc_low_carrier_monitor_inst (.*);

// ### dlc_src_model.sv
`timescale 1ns/1ps
module dlc_src_model (
	input wire logic mclk,
	output logic [6:0] cnt
);
	// Pins ride the top bits so they sit still long enough to pass the synchroniser
	initial cnt = 7'h00;
	always @(posedge mclk) cnt <= cnt + 7'h01;
endmodule // dlc_src_model

// ### tb_dlc_low_carrier.sv
`timescale 1ns/1ps
module tb_dlc_low_carrier;
	logic mclk, reset_n, dis, inv, syn, mod, lc, oe, ha, po;
	logic [3:0] sel;
	logic [6:0] cnt;
	int miscompares, num_checks;
	dlc_src_model dlc_src_model_inst (.mclk(mclk), .cnt(cnt));
	dlc_low_carrier dlc_low_carrier_inst (.mclk(mclk), .reset_n(reset_n),
		.low_carrier_select(sel), .low_carrier_output_disable(dis), .low_carrier_invert(inv),
		.low_carrier_sync_enable(syn), .carrier_input_pin_1(cnt[6]), .carrier_input_pin_2(cnt[5]),
		.reference_clock_out(cnt[0]), .pwmOut1(cnt[1]), .pwmOut2(cnt[2]), .modSource(mod),
		.lowCarrier(lc), .lowCarrierPinOut(po), .lowCarrierPinOe(oe), .highAllowed(ha));
	initial begin
		mclk = 0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic ck(input logic a, input logic b);
		num_checks++;
		if (a !== b) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, a, b);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic tSel;
		logic [5:0] s;
		for (int c = 0; c < 7; c++) for (int i = 0; i < 2; i++) begin
			@(posedge mclk);
			sel <= 4'(c);
			inv <= i[0];
			while (cnt[4:0] != 5'h10) @(posedge mclk);
			#1 s = {cnt[2:0], cnt[5], cnt[6], 1'b0};
			@(posedge mclk);
			#1 ck(lc, (c < 6 ? s[c] : 1'b0) ^ inv);
			ck(po, (c < 6 ? s[c] : 1'b0) ^ inv);
		end
	endtask
	task automatic tDis(input logic d);
		@(posedge mclk);
		dis <= d;
		repeat (2) @(posedge mclk);
		#1 ck(oe, !d);
	endtask
	task automatic tSync;
		// ====
		// Reserved code, inverted: carrier stuck high, no falling edge
		@(posedge mclk);
		syn <= 1'b1;
		mod <= 1'b1;
		repeat (6) @(posedge mclk);
		#1 ck(ha, 1'b0);
		@(posedge mclk);
		sel <= 4'h4;
		repeat (6) @(posedge mclk);
		#1 ck(ha, 1'b1);
		@(posedge mclk);
		mod <= 1'b0;
		repeat (2) @(posedge mclk);
		#1 ck(ha, 1'b0);
		@(posedge mclk);
		syn <= 1'b0;
		mod <= 1'b1;
		repeat (2) @(posedge mclk);
		#1 ck(ha, 1'b1);
	endtask
	initial begin
		{reset_n, dis, inv, syn, mod, sel} = '0;
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		tSel();
		tDis(1'b1);
		tDis(1'b0);
		tSync();
		end_of_test();
	end
	initial begin
		#50000;
		miscompares++;
		end_of_test();
	end
endmodule // tb_dlc_low_carrier
